// ===== hdl/lgt_consts.svh
// Constants for lane gating and test-pattern logic: offsets, fields, resets, codes.
// Assumes inclusion by bare name from the package and design files.
`ifndef LGT_CONSTS_SVH
`define LGT_CONSTS_SVH
// Register byte offsets
`define LGT_OFF_CTRL      4'h0
`define LGT_OFF_FORMAT    4'h4
`define LGT_OFF_PATTERN   4'h8
`define LGT_OFF_STATUS    4'hC
// Control register fields
`define LGT_CTRL_MODE_LSB 0
`define LGT_CTRL_CHA_BIT  8
`define LGT_CTRL_CHB_BIT  9
`define LGT_CTRL_KPA_BIT  10
`define LGT_CTRL_KPB_BIT  11
// Format register fields
`define LGT_FMT_SEL_LSB   0
`define LGT_FMT_LANE_LSB  8
`define LGT_FMT_CONT_LSB  16
// Status register fields
`define LGT_STAT_PIN_BIT  16
// Reset values
`define LGT_RST_MODE      8'h00
`define LGT_RST_FMT       5'h00
`define LGT_RST_LANES     4'h8
`define LGT_RST_CONT      2'h1
`define LGT_RST_PAT       4'h0
// Device operating mode values that keep serializers up
`define LGT_MODE_RUN0     8'h00
`define LGT_MODE_RUN1     8'h01
// Pattern select codes
`define LGT_PAT_NORMAL    4'h0
`define LGT_PAT_PRBS7     4'h1
`define LGT_PAT_PRBS15    4'h2
`define LGT_PAT_PRBS23    4'h3
`define LGT_PAT_RAMP      4'h4
`define LGT_PAT_TRANSPORT 4'h5
// Sample container codes
`define LGT_CONT_8        2'h0
`define LGT_CONT_12       2'h1
`define LGT_CONT_16       2'h2
// PRBS taps as bit distances back in time
`define LGT_P7_A          6
`define LGT_P7_B          7
`define LGT_P15_A         14
`define LGT_P15_B         15
`define LGT_P23_A         18
`define LGT_P23_B         23
`endif

// ===== hdl/lgt_pkg.sv
// Types shared by the lane gating and test-pattern logic.
// Assumes lgt_consts.svh is on the include path.
package lgt_pkg;
  `include "lgt_consts.svh"

  typedef struct packed {
    logic [7:0] mode;
    logic       chanA;
    logic       chanB;
    logic       keepA;
    logic       keepB;
    logic [4:0] fmt;
    logic [3:0] lanes;
    logic [1:0] cont;
    logic [3:0] pat;
  } lgt_cfg_t;

  typedef struct packed {
    logic [15:0]       power;
    logic [15:0]       drive;
    logic [15:0]       bypass;
    logic [15:0][9:0]  sym;
  } lgt_lane_t;

  typedef struct packed {
    lgt_cfg_t          cfg;
    logic              pinS1;
    logic              pinS2;
    logic              waitReq;
    logic [31:0]       readData;
    logic [15:0][22:0] lfsr;
    logic [7:0]        ramp;
    logic [2:0]        oct;
    lgt_lane_t         lo;
  } lgt_state_t;
endpackage

// ===== hdl/lgt_lane_gating.sv
// Serializer lane gating and test-pattern insertion for a two-link, 16-lane transmitter.
// Assumes an Avalon-MM master on clk_sys, a link layer on the same clock and an asynchronous shutdown pin.
//
// Added by the designer: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "lgt_consts.svh"

module lgt_lane_gating (
  input  wire logic                 clk_sys,           // System clock, 40 MHz
  input  wire logic                 rst_n,             // Synchronous reset, active low
  input  wire logic [3:0]           avs_address,       // Byte address
  input  wire logic                 avs_read,          // Read request
  input  wire logic                 avs_write,         // Write request
  input  wire logic [31:0]          avs_writedata,     // Write data
  input  wire logic [3:0]           avs_byteenable,    // Byte lanes of a write
  output logic      [31:0]          avs_readdata,      // Read data
  output logic                      avs_waitrequest,   // Stall, high until answer
  input  wire logic                 full_shutdown_pin, // Asynchronous shutdown pin
  input  wire logic                 dataPhase,         // Link layer past lane alignment
  input  wire logic [15:0][7:0]     fmtData,           // Formatter octets, lanes 0-15 of both links
  input  wire logic [15:0][7:0]     longPatData,       // Long transport pattern octets
  output lgt_pkg::lgt_lane_t        laneOut            // Lane power, drive and symbols
);
  import lgt_pkg::*;

  lgt_state_t s_r;
  lgt_state_t s_nxt;

  // ==========================================================================
  // Pattern functions
  // ==========================================================================
  // Ten bits per cycle, earliest bit in sym[9]
  function automatic logic [32:0] prbsStep(input logic [22:0] st, input logic [3:0] pat);
    logic [22:0] q;
    logic [9:0]  b;
    logic        nb;
    q = st;
    b = 10'h000;
    for (int i = 9; i >= 0; i--) begin
      unique case (pat)
        `LGT_PAT_PRBS15: nb = q[`LGT_P15_A-1] ^ q[`LGT_P15_B-1];
        `LGT_PAT_PRBS23: nb = q[`LGT_P23_A-1] ^ q[`LGT_P23_B-1];
        default:         nb = q[`LGT_P7_A-1] ^ q[`LGT_P7_B-1];
      endcase
      q    = {q[21:0], nb};
      b[i] = nb;
    end
    return {q, b};
  endfunction

  function automatic logic [7:0] short12(input logic [2:0] k, input logic [2:0] idx);
    logic [63:0] v;
    v = {4'hF - {1'b0, k}, {1'b0, k}, 4'h1,
         4'hF - {1'b0, k}, {1'b0, k}, 4'h2,
         4'hF - {1'b0, k}, {1'b0, k}, 4'h3,
         4'hF - {1'b0, k}, {1'b0, k}, 4'h4,
         4'hF - {1'b0, k}, {1'b0, k}, 4'h5, 4'h0};
    return v[8'(63 - 8 * idx) -: 8];
  endfunction

  function automatic logic isPrbs(input logic [3:0] pat);
    return (pat == `LGT_PAT_PRBS7) || (pat == `LGT_PAT_PRBS15) || (pat == `LGT_PAT_PRBS23);
  endfunction

  // ==========================================================================
  // Next state
  // ==========================================================================
  logic [32:0] step;
  logic        modeOk;
  logic        chanOff;
  logic        keep;
  logic        used;
  logic        prbsOn;
  logic [2:0]  k;
  logic [7:0]  oct8;
  logic [3:0]  patEff;

  always_comb begin
    s_nxt   = s_r;
    step    = 33'h0;
    chanOff = 1'b0;
    keep    = 1'b0;
    used    = 1'b0;
    prbsOn  = 1'b0;
    k       = 3'h0;
    oct8    = 8'h00;
    // Pin reaches logic only after two flops
    s_nxt.pinS1 = full_shutdown_pin;
    s_nxt.pinS2 = s_r.pinS1;
    modeOk = (s_r.cfg.mode == `LGT_MODE_RUN0) || (s_r.cfg.mode == `LGT_MODE_RUN1);
    patEff = (s_r.cfg.pat > `LGT_PAT_TRANSPORT) ? `LGT_PAT_NORMAL : s_r.cfg.pat;

    // Avalon slave: one wait cycle, then answer for exactly one cycle
    s_nxt.waitReq = 1'b1;
    if ((avs_read || avs_write) && s_r.waitReq) begin
      s_nxt.waitReq  = 1'b0;
      s_nxt.readData = 32'h0000_0000;
      if (avs_read) begin
        unique case (avs_address)
          `LGT_OFF_CTRL: s_nxt.readData = {20'h0, s_r.cfg.keepB, s_r.cfg.keepA,
                                           s_r.cfg.chanB, s_r.cfg.chanA, s_r.cfg.mode};
          `LGT_OFF_FORMAT: s_nxt.readData = {14'h0, s_r.cfg.cont, 4'h0, s_r.cfg.lanes,
                                             3'h0, s_r.cfg.fmt};
          `LGT_OFF_PATTERN: s_nxt.readData = {28'h0, s_r.cfg.pat};
          `LGT_OFF_STATUS: s_nxt.readData = {15'h0, s_r.pinS2, s_r.lo.power};
          default: s_nxt.readData = 32'h0000_0000;
        endcase
      end
    end
    if (avs_write && !s_r.waitReq) begin
      unique case (avs_address)
        `LGT_OFF_CTRL: begin
          if (avs_byteenable[0]) s_nxt.cfg.mode = avs_writedata[`LGT_CTRL_MODE_LSB +: 8];
          if (avs_byteenable[1]) begin
            s_nxt.cfg.chanA = avs_writedata[`LGT_CTRL_CHA_BIT];
            s_nxt.cfg.chanB = avs_writedata[`LGT_CTRL_CHB_BIT];
            s_nxt.cfg.keepA = avs_writedata[`LGT_CTRL_KPA_BIT];
            s_nxt.cfg.keepB = avs_writedata[`LGT_CTRL_KPB_BIT];
          end
        end
        `LGT_OFF_FORMAT: begin
          if (avs_byteenable[0]) s_nxt.cfg.fmt = avs_writedata[`LGT_FMT_SEL_LSB +: 5];
          if (avs_byteenable[1]) s_nxt.cfg.lanes = avs_writedata[`LGT_FMT_LANE_LSB +: 4];
          if (avs_byteenable[2]) s_nxt.cfg.cont = avs_writedata[`LGT_FMT_CONT_LSB +: 2];
        end
        `LGT_OFF_PATTERN: begin
          // Changing this while the link runs corrupts the stream the receiver sees
          if (avs_byteenable[0]) s_nxt.cfg.pat = avs_writedata[3:0];
        end
        default: begin
        end
      endcase
    end

    // Ramp and frame octet counters start after lane alignment
    if (dataPhase) begin
      s_nxt.ramp = s_r.ramp + 8'h01;
      s_nxt.oct  = s_r.oct + 3'h1;
    end else begin
      s_nxt.ramp = 8'h00;
      s_nxt.oct  = 3'h0;
    end

    // Per-lane gating and pattern selection
    for (int l = 0; l < 16; l++) begin
      k       = 3'(l % 8);
      chanOff = (l < 8) ? s_r.cfg.chanA : s_r.cfg.chanB;
      keep    = (l < 8) ? s_r.cfg.keepA : s_r.cfg.keepB;
      used    = {1'b0, k} < s_r.cfg.lanes;
      s_nxt.lo.power[l] = !s_r.pinS2 && modeOk && !chanOff && (used || keep);
      s_nxt.lo.drive[l] = s_nxt.lo.power[l] && !s_r.pinS2;
      // Unused lanes kept alive toggle on PRBS7 so the serializer never sits static
      prbsOn = isPrbs(patEff) || (!used && keep);
      step   = prbsStep(s_r.lfsr[l], used ? patEff : `LGT_PAT_PRBS7);
      if (prbsOn) begin
        s_nxt.lfsr[l] = step[32:10];
      end else begin
        s_nxt.lfsr[l] = 23'(l + 1);
      end
      s_nxt.lo.bypass[l] = prbsOn;
      oct8 = fmtData[l];
      unique case (patEff)
        `LGT_PAT_RAMP: oct8 = dataPhase ? s_r.ramp : 8'h00;
        `LGT_PAT_TRANSPORT: begin
          unique case (s_r.cfg.cont)
            `LGT_CONT_8:  oct8 = s_r.oct[0] ? ~{6'h00, k[1:0]} : {6'h00, k[1:0]};
            `LGT_CONT_12: oct8 = short12(k, s_r.oct);
            default:      oct8 = longPatData[l];
          endcase
        end
        default: oct8 = fmtData[l];
      endcase
      if (!s_nxt.lo.power[l]) begin
        s_nxt.lo.sym[l] = 10'h000;
      end else if (prbsOn) begin
        s_nxt.lo.sym[l] = step[9:0];
      end else begin
        s_nxt.lo.sym[l] = {2'h0, oct8};
      end
    end

    if (!rst_n) begin
      s_nxt           = '0;
      s_nxt.waitReq   = 1'b1;
      s_nxt.cfg.mode  = `LGT_RST_MODE;
      s_nxt.cfg.fmt   = `LGT_RST_FMT;
      s_nxt.cfg.lanes = `LGT_RST_LANES;
      s_nxt.cfg.cont  = `LGT_RST_CONT;
      s_nxt.cfg.pat   = `LGT_RST_PAT;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_r <= s_nxt;
  end

  assign avs_readdata    = s_r.readData;
  assign avs_waitrequest = s_r.waitReq;
  assign laneOut         = s_r.lo;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Lane 0 symbol history; one flop per step gives the same view as a look back in the property
  logic [9:0]  symD1_r;
  logic [9:0]  symD2_r;
  logic [19:0] cat2;
  logic [29:0] cat3;

  always_ff @(posedge clk_sys) begin
    symD1_r <= s_r.lo.sym[0];
    symD2_r <= symD1_r;
  end

  assign cat2 = {symD1_r, s_r.lo.sym[0]};
  assign cat3 = {symD2_r, symD1_r, s_r.lo.sym[0]};

  sequence sPrbsHeld(logic [3:0] code);
    (s_r.cfg.pat == code && s_r.lo.power[0] && s_r.lo.bypass[0])[*4];
  endsequence

  property p_pinOff;
    s_r.pinS2 |=> (s_r.lo.drive == 16'h0000);
  endproperty
  a_pinOff: assert property (p_pinOff) else $error("lanes driven during shutdown");

  property p_modeOff;
    (s_r.cfg.mode > `LGT_MODE_RUN1) |=> (s_r.lo.power == 16'h0000);
  endproperty
  a_modeOff: assert property (p_modeOff) else $error("lanes powered in bad mode");

  property p_chanOff;
    s_r.cfg.chanA |=> (s_r.lo.power[7:0] == 8'h00);
  endproperty
  a_chanOff: assert property (p_chanOff) else $error("channel lanes up while shut");

  property p_fmtOff;
    (!s_r.cfg.keepB && s_r.cfg.lanes == 4'h4) |=> (s_r.lo.power[15:12] == 4'h0);
  endproperty
  a_fmtOff: assert property (p_fmtOff) else $error("unused lanes powered");

  property p_keep;
    (s_r.cfg.keepA && !s_r.cfg.chanA && !s_r.pinS2 && s_r.cfg.mode == `LGT_MODE_RUN0)
      |=> (s_r.lo.power[7:0] == 8'hFF);
  endproperty
  a_keep: assert property (p_keep) else $error("keepalive lanes not powered");

  property p_bypass;
    (s_r.cfg.pat == `LGT_PAT_PRBS23 && s_r.cfg.lanes != 4'h0) |=> s_r.lo.bypass[0];
  endproperty
  a_bypass: assert property (p_bypass) else $error("prbs not bypassing encoder");

  property p_prbs7;
    sPrbsHeld(`LGT_PAT_PRBS7) |-> (cat2[0] == (cat2[6] ^ cat2[7])) && (cat2[3] == (cat2[9] ^ cat2[10]));
  endproperty
  a_prbs7: assert property (p_prbs7) else $error("prbs7 recurrence broken");

  property p_prbs15;
    sPrbsHeld(`LGT_PAT_PRBS15) |-> (cat2[0] == (cat2[14] ^ cat2[15])) && (cat2[4] == (cat2[18] ^ cat2[19]));
  endproperty
  a_prbs15: assert property (p_prbs15) else $error("prbs15 recurrence broken");

  property p_prbs23;
    sPrbsHeld(`LGT_PAT_PRBS23) |-> (cat3[0] == (cat3[18] ^ cat3[23])) && (cat3[6] == (cat3[24] ^ cat3[29]));
  endproperty
  a_prbs23: assert property (p_prbs23) else $error("prbs23 recurrence broken");

  property p_ramp;
    (s_r.cfg.pat == `LGT_PAT_RAMP && dataPhase && s_r.lo.power[0])[*2]
      |=> (s_r.lo.sym[0][7:0] == $past(s_r.lo.sym[0][7:0]) + 8'h01);
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp did not step by one");

  property p_short8;
    (s_r.cfg.pat == `LGT_PAT_TRANSPORT && s_r.cfg.cont == `LGT_CONT_8 && dataPhase && s_r.lo.power[1])[*2]
      |=> (s_r.lo.sym[1][7:0] == ~$past(s_r.lo.sym[1][7:0])) && (s_r.lo.sym[1][1:0] == 2'h1 || s_r.lo.sym[1][1:0] == 2'h2);
  endproperty
  a_short8: assert property (p_short8) else $error("short 8-bit pattern wrong");

  property p_normal;
    (s_r.cfg.pat > `LGT_PAT_TRANSPORT && s_r.lo.power[0] && s_r.cfg.lanes != 4'h0)
      |=> (s_r.lo.sym[0] == {2'h0, $past(fmtData[0])}) && !s_r.lo.bypass[0];
  endproperty
  a_normal: assert property (p_normal) else $error("unassigned code not normal");

  property p_chanOffB;
    s_r.cfg.chanB |=> (s_r.lo.power[15:8] == 8'h00);
  endproperty
  a_chanOffB: assert property (p_chanOffB) else $error("link B lanes up while shut");

  // A fresh data phase must restart the ramp at zero, not resume an old count
  sequence sRampIdle;
    s_r.cfg.pat == `LGT_PAT_RAMP && !dataPhase;
  endsequence

  sequence sRampGo;
    s_r.cfg.pat == `LGT_PAT_RAMP && dataPhase;
  endsequence

  property p_rampStart;
    sRampIdle ##1 sRampGo |=> (!s_r.lo.power[0] || s_r.lo.sym[0][7:0] == 8'h00);
  endproperty
  a_rampStart: assert property (p_rampStart) else $error("ramp did not start at zero");

  property p_short12;
    (s_r.cfg.pat == `LGT_PAT_TRANSPORT && s_r.cfg.cont == `LGT_CONT_12 && s_r.oct == 3'h0)
      |=> (!s_r.lo.power[0] || s_r.lo.sym[0] == 10'h0F0);
  endproperty
  a_short12: assert property (p_short12) else $error("short 12-bit pattern wrong");

  // Spare lanes kept alive must keep changing, or the serializer sits static
  sequence sKeepSpare;
    (s_r.cfg.keepA && !s_r.cfg.chanA && !s_r.pinS2 && s_r.cfg.mode == `LGT_MODE_RUN0 && s_r.cfg.lanes < 4'h8)[*2];
  endsequence

  property p_keepToggle;
    sKeepSpare |=> s_r.lo.bypass[7] && s_r.lo.power[7] && (s_r.lo.sym[7] != $past(s_r.lo.sym[7]));
  endproperty
  a_keepToggle: assert property (p_keepToggle) else $error("kept-alive lane not toggling");

  property p_unusedDark;
    (s_r.cfg.pat == `LGT_PAT_TRANSPORT && !s_r.cfg.keepA && s_r.cfg.lanes == 4'h6)
      |=> (s_r.lo.sym[7:6] == 20'h00000);
  endproperty
  a_unusedDark: assert property (p_unusedDark) else $error("disabled lane carries pattern");
endmodule

// ===== sim/lgt_rx_model.sv
// Receiver model: aligns the link and checks the PRBS recurrence on lane 0.
// Assumes the bench enables the link and sets the tap distances.
`timescale 1ns/1ps
module lgt_rx_model #(
  parameter int ALIGN = 6 // Alignment cycles, plain default
) (
  input  wire logic               clk_sys,   // Device clock
  input  wire logic               rst_n,     // Reset, active low
  input  wire logic               linkEn,    // Link enabled by host
  input  wire lgt_pkg::lgt_lane_t laneIn,    // Lanes from the block
  input  wire logic [4:0]         tapA,      // Near tap distance
  input  wire logic [4:0]         tapB,      // Far tap distance
  output logic                    dataPhase, // Past lane alignment
  output int                      badBits    // Failed recurrence bits
);
  import lgt_pkg::*;
  logic [29:0] hist;
  int          cnt;
  int          seen;
  int          n;
  logic [29:0] h;
  int          e;
  // =====
  // Alignment: lost power means a fresh link
  always @(posedge clk_sys) begin
    if (!rst_n || !linkEn || laneIn.power[0] !== 1'b1) begin
      cnt <= 0;
      dataPhase <= 1'b0;
    end else begin
      if (cnt < ALIGN) cnt <= cnt + 1;
      dataPhase <= (cnt == ALIGN);
    end
  end
  // =====
  // Self-synchronising check, needs three symbols of history
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      seen <= 0;
      badBits <= 0;
    end else if (linkEn && laneIn.bypass[0] === 1'b1) begin
      h = {hist[19:0], laneIn.sym[0]};
      hist <= h;
      seen <= seen + 1;
      e = 0;
      if (seen >= 2)
        for (n = tapB; n < 30; n++)
          if (h[29-n] !== (h[29-n+tapA] ^ h[29-n+tapB])) e++;
      badBits <= badBits + e;
    end else seen <= 0;
  end
endmodule

// ===== sim/test_serdes_lane_gating_test_patterns.sv
// Self-checking bench for the lane gating and test-pattern block.
// Assumes the design package, the receiver model and a 40 MHz clock.
`timescale 1ns/1ps
module test_serdes_lane_gating_test_patterns;
  import lgt_pkg::*;
  logic             clk_sys = 1'b0;
  logic             rst_n = 1'b0;
  logic [3:0]       avs_address = 4'h0;
  logic             avs_read = 1'b0;
  logic             avs_write = 1'b0;
  logic [31:0]      avs_writedata = 32'h0;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic             full_shutdown_pin = 1'b0;
  logic             dataPhase;
  logic             linkEn = 1'b0;
  logic [15:0][7:0] fmtData = '0;
  logic [15:0][7:0] longPatData = '0;
  logic [15:0][7:0] prv;
  logic [4:0]       tapA = 5'h0;
  logic [4:0]       tapB = 5'h0;
  lgt_lane_t        laneOut;
  logic [31:0]      expQ[$];
  logic [63:0]      pv;
  logic [7:0]       r;
  int               badBits;
  int               num_errors = 0;
  int               n_compared = 0;
  int               i, l, t;

  always #12.5 clk_sys = ~clk_sys;

  lgt_lane_gating dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .full_shutdown_pin(full_shutdown_pin), .dataPhase(dataPhase),
    .fmtData(fmtData), .longPatData(longPatData), .laneOut(laneOut));
  lgt_rx_model rx (.clk_sys(clk_sys), .rst_n(rst_n), .linkEn(linkEn), .laneIn(laneOut), .tapA(tapA),
    .tapB(tapB), .dataPhase(dataPhase), .badBits(badBits));

  // =====
  // Checking and bus tasks
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic compare(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Idle edge after release so no signal is driven twice in one step
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin @(posedge clk_sys); k++; end while (avs_waitrequest !== 1'b0 && k < 20);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 20) begin num_errors++; test_done(); end
    @(posedge clk_sys);
  endtask

  task automatic rd(logic [3:0] a, logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  always @(posedge clk_sys)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) compare("read data", expQ.pop_front(), avs_readdata);

  function automatic logic [15:0] pwr(logic [7:0] m, logic [3:0] c, logic [3:0] ln);
    logic [15:0] p;
    for (int q = 0; q < 16; q++) p[q] = (m <= 8'h01) && !c[q/8] && ((q % 8) < ln || c[2+q/8]);
    return p;
  endfunction

  function automatic logic [63:0] pat12(int k);
    logic [63:0] v;
    v = '0;
    for (int s = 1; s <= 5; s++) v[75-12*s -: 12] = {4'(15-k), 4'(k), 4'(s)};
    return v;
  endfunction

  // Pattern only changes with the link down
  task automatic setpat(logic [3:0] p, logic [3:0] ln, logic [1:0] ct, logic [4:0] a, logic [4:0] b);
    int k;
    linkEn <= 1'b0;
    bus(1'b1, 4'h8, {28'h0, p});
    bus(1'b1, 4'h4, {14'h0, ct, 4'h0, ln, 8'h0});
    tapA <= a;
    tapB <= b;
    repeat (3) @(posedge clk_sys);
    linkEn <= 1'b1;
    k = 0;
    while (dataPhase !== 1'b1 && k < 50) begin @(posedge clk_sys); k++; end
    if (k >= 50) begin num_errors++; test_done(); end
  endtask

  // =====
  // Main sequence
  initial begin
    void'($urandom(75989));
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0001_0800);
    rd(4'h8, 32'h0);
    rd(4'hC, 32'h0000_FFFF);
    rd(4'h2, 32'h0);
    for (i = 0; i < 12; i++) begin
      t = (i == 0) ? 4 : $urandom;
      r = (i % 3 == 2) ? 8'($urandom_range(255, 2)) : 8'(i % 2);
      l = (i == 0) ? 4 : $urandom_range(8, 0);
      bus(1'b1, 4'h0, {20'h0, 4'(t), r});
      bus(1'b1, 4'h4, {14'h0, 2'h1, 4'h0, 4'(l), 8'h0});
      rd(4'hC, {16'h0, pwr(r, 4'(t), 4'(l))});
    end
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b1, 4'h4, 32'h0001_0800);
    full_shutdown_pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    compare("lane drive", 32'h0, {16'h0, laneOut.drive});
    rd(4'hC, 32'h0001_0000);
    full_shutdown_pin <= 1'b0;
    for (i = 0; i < 16; i++) if (i == 0 || i > 5) begin
      fmtData <= {$urandom, $urandom, $urandom, $urandom};
      setpat(4'(i), 4'h8, 2'h1, 5'd6, 5'd7);
      for (l = 0; l < 16; l++) compare("normal octet", {24'h0, fmtData[l]}, {22'h0, laneOut.sym[l]});
      compare("bypass", 32'h0, {16'h0, laneOut.bypass});
    end
    for (i = 1; i < 4; i++) begin
      setpat(4'(i), 4'h4, 2'h1, 5'(i == 1 ? 6 : i == 2 ? 14 : 18), 5'(i == 1 ? 7 : i == 2 ? 15 : 23));
      repeat (40) @(posedge clk_sys);
      compare("prbs bad bits", 32'h0, 32'(badBits));
      compare("power", 32'h0F0F, {16'h0, laneOut.power});
      compare("bypass", 32'h1, {31'h0, laneOut.bypass[0]});
      compare("lanes differ", 32'h1, {31'h0, laneOut.sym[0] !== laneOut.sym[1]});
    end
    setpat(4'h4, 4'h8, 2'h1, 5'd6, 5'd7);
    @(posedge clk_sys);
    r = laneOut.sym[0][7:0];
    compare("ramp start", 32'h0, {24'h0, r});
    for (t = 0; t < 300; t++) begin
      @(posedge clk_sys);
      r++;
      for (l = 0; l < 16; l++) compare("ramp octet", {24'h0, r}, {22'h0, laneOut.sym[l]});
    end
    setpat(4'h5, 4'h8, 2'h0, 5'd6, 5'd7);
    for (t = 0; t < 4; t++) begin
      @(posedge clk_sys);
      for (l = 0; l < 16; l++) begin
        if (t == 0) compare("short8 start", 32'h1,
          {31'h0, laneOut.sym[l] === 10'(l % 4) || laneOut.sym[l] === {2'b0, ~8'(l % 4)}});
        else compare("short8 octet", {24'h0, ~prv[l]}, {22'h0, laneOut.sym[l]});
        prv[l] = laneOut.sym[l][7:0];
      end
    end
    setpat(4'h5, 4'h6, 2'h1, 5'd6, 5'd7);
    t = 0;
    while (laneOut.sym[0][7:0] !== 8'h50 && t < 20) begin @(posedge clk_sys); t++; end
    if (t >= 20) begin num_errors++; test_done(); end
    for (t = 0; t < 8; t++) begin
      @(posedge clk_sys);
      for (l = 0; l < 16; l++) begin
        pv = (l % 8 < 6) ? pat12(l % 8) : 64'h0;
        compare("short12 octet", {24'h0, pv[63-8*t -: 8]}, {22'h0, laneOut.sym[l]});
      end
    end
    longPatData <= {$urandom, $urandom, $urandom, $urandom};
    setpat(4'h5, 4'h8, 2'h2, 5'd6, 5'd7);
    for (l = 0; l < 16; l++) compare("long octet", {24'h0, longPatData[l]}, {22'h0, laneOut.sym[l]});
    test_done();
  end
endmodule
